// ===== hdl/pcra_config_access.v
// paged configuration registers behind a two-wire or spi serial port, with nvm download
`timescale 1ns/1ps
`include "pcra_regs.vh"

// Function
// - zero delay mode set by software opens the internal feedback path for external feedback.
// - zero delay mode blocks automatic input selection and hitless switching.
// - power-up initialization holds every output divider in reset for aligned phase.
// - the reset pin or hard reset bit repeats the full initialization and divider realignment.
// - the sync bit realigns the output dividers without touching any register.
// - at power-up the defaults are downloaded from the nonvolatile store before operation.
// - the nonvolatile store takes at most two programming operations in its life.
// - after programming only the newest image is loaded and the older one is gone.
// - all configuration is by register access over the serial port that the select pin picks.
// - spi runs four-wire with separate data out or three-wire on the shared data line.
// - each page holds 256 byte registers.
// - an address is an 8-bit page over an 8-bit register index.
// - after reset the current page is page 0x00.
// - index 0x01 selects the page on every page.
// - unused input receivers and output drivers power down one by one under register control.
module pcra_config_access (
    // clock and power-on reset
    input wire mclk,
    input wire reset,
    // device pins
    input wire rst_pin_n,
    input wire i2c_sel,
    input wire scl_sclk,
    input wire cs_n_a0,
    input wire sda_sdio_in,
    output reg sda_sdio_out,
    output reg sda_sdio_oe,
    output reg sdo_out,
    output reg sdo_oe,
    // clock path control
    output reg device_ready,
    output reg div_reset,
    output reg div_sync,
    output reg zero_delay_en,
    output reg int_fb_open,
    output reg external_feedback_input_en,
    output reg auto_switch_en,
    output reg hitless_en,
    output reg [9:0] out_pd,
    output reg [3:0] in_pd
);

localparam ST_LOAD = 2'b01;
localparam ST_RUN = 2'b10;

// synchronisers, stage one read only by stage two
reg scl_s1, scl_s2, scl_s3;
reg sda_s1, sda_s2, sda_s3;
reg cs_s1, cs_s2;
reg rstp_s1, rstp_s2;
reg sel_s1, sel_s2;

// serial engine
reg [3:0] bcnt_r;
reg [1:0] k_r;
reg [7:0] sh_r;
reg [7:0] tx_r;
reg [7:0] idx_r;
reg rd_r;
reg adr_r;
reg wr_stb_r;
reg [7:0] wr_dat_r;

// configuration state
reg [1:0] state_r;
reg [7:0] cnt_r;
reg [7:0] page_r;
reg spi3w_r;
reg zdm_r;
reg [1:0] sw_r;
reg [1:0] nvm_cnt_r;
reg [`PCRA_IMG_W-1:0] nvm_a_r;
reg [`PCRA_IMG_W-1:0] nvm_b_r;

wire scl_rise = scl_s2 & ~scl_s3;
wire scl_fall = ~scl_s2 & scl_s3;
wire i2c_start = sel_s2 & scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
wire i2c_stop = sel_s2 & scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
wire [7:0] got = {sh_r[6:0], sda_s2};
wire [`PCRA_IMG_W-1:0] cur_img = {sw_r, zdm_r, in_pd, out_pd, spi3w_r};
// newest image only, older burns are unreachable
wire [`PCRA_IMG_W-1:0] act_img = (nvm_cnt_r == 2'h2) ? nvm_b_r :
    (nvm_cnt_r == 2'h1) ? nvm_a_r : `PCRA_FACTORY_IMG;
wire [15:0] wr_addr = {page_r, idx_r};

// read mux over the current page, 256 indices per page
function [7:0] reg_rd;
    input [7:0] i;
    begin
        reg_rd = 8'h00;
        if (!device_ready)
            reg_rd = 8'h00;
        else if (i == `PCRA_PAGE_SEL_IDX)
            reg_rd = page_r;
        else if (i == `PCRA_READY_IDX)
            reg_rd = 8'h01;
        else begin
            case ({page_r, i})
                `PCRA_SPI_CFG_ADDR: reg_rd = {4'h0, spi3w_r, 3'h0};
                `PCRA_NVM_CNT_ADDR: reg_rd = {6'h00, nvm_cnt_r};
                `PCRA_OUT_PD_LO_ADDR: reg_rd = out_pd[7:0];
                `PCRA_OUT_PD_HI_ADDR: reg_rd = {6'h00, out_pd[9:8]};
                `PCRA_ZDM_ADDR: reg_rd = {7'h00, zdm_r};
                `PCRA_SW_MODE_ADDR: reg_rd = {6'h00, sw_r};
                `PCRA_IN_PD_ADDR: reg_rd = {4'h0, in_pd};
                default: reg_rd = 8'h00;
            endcase
        end
    end
endfunction

// two flops on every pin before use
always @(posedge mclk or posedge reset) begin
    if (reset) begin
        {scl_s1, scl_s2, scl_s3} <= 3'h7;
        {sda_s1, sda_s2, sda_s3} <= 3'h7;
        {cs_s1, cs_s2} <= 2'h3;
        {rstp_s1, rstp_s2} <= 2'h3;
        {sel_s1, sel_s2} <= 2'h0;
    end else begin
        {scl_s1, scl_s2, scl_s3} <= {scl_sclk, scl_s1, scl_s2};
        {sda_s1, sda_s2, sda_s3} <= {sda_sdio_in, sda_s1, sda_s2};
        {cs_s1, cs_s2} <= {cs_n_a0, cs_s1};
        {rstp_s1, rstp_s2} <= {rst_pin_n, rstp_s1};
        {sel_s1, sel_s2} <= {i2c_sel, sel_s1};
    end
end

// serial engine: bytes are sampled on sclk rise, data driven on sclk fall
always @(posedge mclk or posedge reset) begin
    if (reset) begin
        bcnt_r <= 4'h0;
        k_r <= 2'h0;
        sh_r <= 8'h00;
        tx_r <= 8'h00;
        idx_r <= 8'h00;
        rd_r <= 1'b0;
        adr_r <= 1'b0;
        wr_stb_r <= 1'b0;
        wr_dat_r <= 8'h00;
        sda_sdio_out <= 1'b0;
        sda_sdio_oe <= 1'b0;
        sdo_out <= 1'b0;
        sdo_oe <= 1'b0;
    end else begin
        wr_stb_r <= 1'b0;
        if (sel_s2 ? (i2c_start | i2c_stop) : cs_s2) begin
            bcnt_r <= 4'h0;
            k_r <= 2'h0;
            sda_sdio_oe <= 1'b0;
            sdo_oe <= 1'b0;
            if (!sel_s2 || i2c_stop)
                adr_r <= 1'b0;
        end else if (scl_rise) begin
            if (bcnt_r == 4'h8) begin
                bcnt_r <= 4'h0; // acknowledge slot done
            end else begin
                sh_r <= got;
                bcnt_r <= bcnt_r + 4'h1;
                if (bcnt_r == 4'h7) begin
                    if (!sel_s2)
                        bcnt_r <= 4'h0; // spi has no acknowledge slot
                    if (k_r != 2'h2)
                        k_r <= k_r + 2'h1;
                    case (k_r)
                        2'h0: begin
                            if (sel_s2) begin
                                // not ready means no acknowledge at all
                                adr_r <= device_ready & (got[7:1] == `PCRA_I2C_ADDR);
                                rd_r <= got[0];
                                tx_r <= reg_rd(idx_r);
                            end else begin
                                rd_r <= got[7];
                            end
                        end
                        2'h1: begin
                            if (!sel_s2 || !rd_r) begin
                                idx_r <= got;
                                tx_r <= reg_rd(got);
                            end
                            if (sel_s2 && rd_r)
                                tx_r <= reg_rd(idx_r);
                        end
                        default: begin
                            if (!rd_r && device_ready && (adr_r || !sel_s2)) begin
                                wr_stb_r <= 1'b1;
                                wr_dat_r <= got;
                            end
                        end
                    endcase
                end
            end
        end else if (scl_fall) begin
            if (sel_s2) begin
                // open drain: only ever pulls low
                sda_sdio_out <= 1'b0;
                if (bcnt_r == 4'h8) begin
                    sda_sdio_oe <= adr_r & ((k_r == 2'h1) | ~rd_r);
                end else if (adr_r && rd_r && k_r != 2'h0) begin
                    sda_sdio_oe <= ~tx_r[7];
                    tx_r <= {tx_r[6:0], tx_r[7]}; // rotate so the next read byte repeats
                end else begin
                    sda_sdio_oe <= 1'b0;
                end
            end else if (rd_r && k_r == 2'h2) begin
                tx_r <= {tx_r[6:0], 1'b0};
                if (spi3w_r) begin
                    sda_sdio_out <= tx_r[7];
                    sda_sdio_oe <= 1'b1;
                end else begin
                    sdo_out <= tx_r[7];
                    sdo_oe <= 1'b1;
                end
            end
        end
    end
end

// download, resets, realignment and register writes
always @(posedge mclk or posedge reset) begin
    if (reset) begin
        state_r <= ST_LOAD;
        cnt_r <= 8'h00;
        page_r <= `PCRA_PAGE_RST;
        spi3w_r <= 1'b0;
        zdm_r <= 1'b0;
        sw_r <= 2'h0;
        out_pd <= 10'h000;
        in_pd <= 4'h0;
        nvm_cnt_r <= `PCRA_NVM_CNT_RST;
        nvm_a_r <= `PCRA_IMG_RST;
        nvm_b_r <= `PCRA_IMG_RST;
        device_ready <= 1'b0;
        div_reset <= 1'b1;
        div_sync <= 1'b0;
    end else begin
        div_sync <= 1'b0;
        case (state_r)
            ST_LOAD: begin
                device_ready <= 1'b0;
                div_reset <= 1'b1;
                page_r <= `PCRA_PAGE_RST;
                if (!rstp_s2)
                    cnt_r <= 8'h00; // held while the pin is low
                else if (cnt_r == `PCRA_LOAD_CYC - 8'h01) begin
                    {sw_r, zdm_r, in_pd, out_pd, spi3w_r} <= act_img;
                    device_ready <= 1'b1;
                    div_reset <= 1'b0;
                    state_r <= ST_RUN;
                end else
                    cnt_r <= cnt_r + 8'h01;
            end
            ST_RUN: begin
                if (!rstp_s2) begin
                    state_r <= ST_LOAD;
                    cnt_r <= 8'h00;
                    device_ready <= 1'b0;
                    div_reset <= 1'b1;
                end else if (wr_stb_r) begin
                    if (idx_r == `PCRA_PAGE_SEL_IDX)
                        page_r <= wr_dat_r;
                    else begin
                        case (wr_addr)
                            `PCRA_RESET_CTRL_ADDR: begin
                                if (wr_dat_r[`PCRA_HARD_RST_BIT]) begin
                                    state_r <= ST_LOAD;
                                    cnt_r <= 8'h00;
                                    device_ready <= 1'b0;
                                    div_reset <= 1'b1;
                                end else if (wr_dat_r[`PCRA_SYNC_BIT])
                                    div_sync <= 1'b1;
                            end
                            `PCRA_SPI_CFG_ADDR: spi3w_r <= wr_dat_r[`PCRA_SPI3W_BIT];
                            `PCRA_NVM_CMD_ADDR: begin
                                // a third burn is silently refused
                                if (wr_dat_r == `PCRA_NVM_BURN_KEY &&
                                        nvm_cnt_r != `PCRA_NVM_MAX_BURNS) begin
                                    if (nvm_cnt_r == 2'h0)
                                        nvm_a_r <= cur_img;
                                    else
                                        nvm_b_r <= cur_img;
                                    nvm_cnt_r <= nvm_cnt_r + 2'h1;
                                end
                            end
                            `PCRA_OUT_PD_LO_ADDR: out_pd[7:0] <= wr_dat_r;
                            `PCRA_OUT_PD_HI_ADDR: out_pd[9:8] <= wr_dat_r[1:0];
                            `PCRA_ZDM_ADDR: zdm_r <= wr_dat_r[`PCRA_ZDM_BIT];
                            `PCRA_SW_MODE_ADDR: sw_r <= wr_dat_r[1:0];
                            `PCRA_IN_PD_ADDR: in_pd <= wr_dat_r[3:0];
                            default: ;
                        endcase
                    end
                end
            end
            default: state_r <= ST_LOAD;
        endcase
    end
end

// feedback and switching controls follow zero delay mode one cycle later
always @(posedge mclk or posedge reset) begin
    if (reset) begin
        zero_delay_en <= 1'b0;
        int_fb_open <= 1'b0;
        external_feedback_input_en <= 1'b0;
        auto_switch_en <= 1'b0;
        hitless_en <= 1'b0;
    end else begin
        zero_delay_en <= zdm_r;
        int_fb_open <= zdm_r;
        external_feedback_input_en <= zdm_r;
        auto_switch_en <= sw_r[`PCRA_AUTO_SW_BIT] & ~zdm_r;
        hitless_en <= sw_r[`PCRA_HITLESS_BIT] & ~zdm_r;
    end
end

endmodule

// ===== hdl/pcra_regs.vh
// register offsets, field positions, reset values and counts of the config access block
`ifndef PCRA_REGS_VH
`define PCRA_REGS_VH

// register indices decoded on every page, and the page loaded at reset
`define PCRA_PAGE_SEL_IDX 8'h01
`define PCRA_PAGE_RST 8'h00
`define PCRA_READY_IDX 8'hfe

// full 16-bit addresses, page in the upper byte
`define PCRA_RESET_CTRL_ADDR 16'h001c
`define PCRA_SPI_CFG_ADDR 16'h002b
`define PCRA_NVM_CMD_ADDR 16'h00e3
`define PCRA_NVM_CNT_ADDR 16'h00e4
`define PCRA_OUT_PD_LO_ADDR 16'h0141
`define PCRA_OUT_PD_HI_ADDR 16'h0142
`define PCRA_ZDM_ADDR 16'h0487
`define PCRA_SW_MODE_ADDR 16'h0536
`define PCRA_IN_PD_ADDR 16'h0949

// field positions
`define PCRA_HARD_RST_BIT 1
`define PCRA_SYNC_BIT 2
`define PCRA_SPI3W_BIT 3
`define PCRA_ZDM_BIT 0
`define PCRA_AUTO_SW_BIT 0
`define PCRA_HITLESS_BIT 1

// nonvolatile store
`define PCRA_NVM_BURN_KEY 8'hc7
`define PCRA_NVM_MAX_BURNS 2'h2
`define PCRA_NVM_CNT_RST 2'h0
`define PCRA_IMG_W 18
// image layout {sw_mode[1:0], zdm, in_pd[3:0], out_pd[9:0], spi3w}
`define PCRA_FACTORY_IMG 18'h30000
`define PCRA_IMG_RST 18'h00000

// default download length in mclk cycles
`define PCRA_LOAD_CYC 8'h10

// serial slave address on the two-wire bus
`define PCRA_I2C_ADDR 7'h68

`endif

// ===== verif/pcra_config_access_sva.sv
// assertions on the pins of the paged config access block
`timescale 1ns/1ps
module pcra_config_access_sva (
    // clock and reset
    input wire mclk,
    input wire reset,
    // serial side
    input wire rst_pin_n,
    input wire i2c_sel,
    input wire cs_n_a0,
    input wire sda_sdio_oe,
    input wire sdo_oe,
    // clock path controls
    input wire device_ready,
    input wire div_reset,
    input wire div_sync,
    input wire zero_delay_en,
    input wire int_fb_open,
    input wire external_feedback_input_en,
    input wire auto_switch_en,
    input wire hitless_en
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // a load keeps the dividers held and the port closed for a while
    sequence s_loading;
        (div_reset && !device_ready)[*8];
    endsequence
    property p_load_hold;
        $rose(div_reset) |=> s_loading;
    endproperty
    a_load_hold: assert property (p_load_hold) else $error("load too short");
    // pin release: still loading, then dividers free within the load length
    property p_pin_reload;
        $rose(rst_pin_n) |-> s_loading ##[8:24] !div_reset;
    endproperty
    a_pin_reload: assert property (p_pin_reload) else $error("pin reload wrong");
    property p_ready_free;
        device_ready |-> !div_reset;
    endproperty
    a_ready_free: assert property (p_ready_free) else $error("ready during load");
    property p_sync_pulse;
        div_sync |-> device_ready && !div_reset ##1 !div_sync;
    endproperty
    a_sync_pulse: assert property (p_sync_pulse) else $error("sync not clean");
    property p_zdm_fb;
        int_fb_open == zero_delay_en && external_feedback_input_en == zero_delay_en;
    endproperty
    a_zdm_fb: assert property (p_zdm_fb) else $error("feedback path wrong");
    property p_zdm_sw;
        zero_delay_en && $past(zero_delay_en) |-> !auto_switch_en && !hitless_en;
    endproperty
    a_zdm_sw: assert property (p_zdm_sw) else $error("switching in zero delay");
    property p_quiet_unready;
        !device_ready |-> !sdo_oe && !sda_sdio_oe;
    endproperty
    a_quiet_unready: assert property (p_quiet_unready) else $error("drives unready");
    property p_cs_release;
        (cs_n_a0 && !i2c_sel)[*5] |-> !sdo_oe && !sda_sdio_oe;
    endproperty
    a_cs_release: assert property (p_cs_release) else $error("drives deselected");
    property p_one_pin;
        !i2c_sel |-> !(sdo_oe && sda_sdio_oe);
    endproperty
    a_one_pin: assert property (p_one_pin) else $error("both data pins driven");
endmodule

bind pcra_config_access pcra_config_access_sva pcra_config_access_sva_i (
    .mclk(mclk), .reset(reset), .rst_pin_n(rst_pin_n), .i2c_sel(i2c_sel),
    .cs_n_a0(cs_n_a0), .sda_sdio_oe(sda_sdio_oe), .sdo_oe(sdo_oe),
    .device_ready(device_ready), .div_reset(div_reset), .div_sync(div_sync),
    .zero_delay_en(zero_delay_en), .int_fb_open(int_fb_open),
    .external_feedback_input_en(external_feedback_input_en),
    .auto_switch_en(auto_switch_en), .hitless_en(hitless_en));

// ===== verif/pcra_spi_host.sv
// spi host model on the serial pins, four-wire or three-wire
`timescale 1ns/1ps
module pcra_spi_host (
    // clock and variant
    input wire mclk,
    input wire three_wire,
    // serial pins
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire sdo,
    input wire sdio
);
    // idle: clock stands high, chip deselected
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    // one bit per 15 mclk, data set on the fall, taken at the rise
    task automatic bit_io(input logic b, output logic r);
        @(negedge mclk) sclk = 1'b0;
        sdi = b;
        repeat (7) @(negedge mclk);
        sclk = 1'b1;
        r = three_wire ? sdio : sdo;
        repeat (7) @(negedge mclk);
    endtask
    // command, index, data; a read lets the line toggle so stale bits cannot pass
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd);
        logic r;
        @(negedge mclk) cs_n = 1'b0;
        for (int i = 7; i >= 0; i--) bit_io(cmd[i], r);
        for (int i = 7; i >= 0; i--) bit_io(idx[i], r);
        for (int i = 7; i >= 0; i--) bit_io(cmd[7] ? ~sdi : wd[i], rd[i]);
        cs_n = 1'b1;
        repeat (6) @(negedge mclk);
    endtask
endmodule

// ===== verif/test_pcra_config_access.sv
// self-checking bench for the paged config access block
`timescale 1ns/1ps
`include "pcra_regs.vh"
module test_pcra_config_access;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic rst_pin_n = 1'b1;
    logic i2c_sel = 1'b0;
    logic three_wire = 1'b0;
    wire sclk, cs_n, sdi, sdio, sda_sdio_out, sda_sdio_oe, sdo_out, sdo_oe;
    wire device_ready, div_reset, div_sync, zero_delay_en, int_fb_open, ext_fb_en;
    wire auto_switch_en, hitless_en;
    wire [9:0] out_pd;
    wire [3:0] in_pd;
    int n_fail = 0;
    int num_checks = 0;
    int n_sync = 0;
    logic [7:0] rd;
    // ordinary accesses: {address, write data, read back}
    localparam logic [31:0] ROWS [0:8] = '{32'h0141ffff, 32'h01420202, 32'h09490a0a,
        32'h05360303, 32'h04870101, 32'h00fe0001, 32'h02005a00, 32'h001c0000, 32'h00e40500};
    always #5 mclk = ~mclk;
    // shared data line: the block wins while it drives, else the host
    assign sdio = sda_sdio_oe ? sda_sdio_out : sdi;
    always @(posedge mclk) if (div_sync === 1'b1) n_sync <= n_sync + 1;
    pcra_config_access pcra_config_access_i (.mclk(mclk), .reset(reset),
        .rst_pin_n(rst_pin_n), .i2c_sel(i2c_sel), .scl_sclk(sclk), .cs_n_a0(cs_n),
        .sda_sdio_in(sdio), .sda_sdio_out(sda_sdio_out), .sda_sdio_oe(sda_sdio_oe),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .device_ready(device_ready),
        .div_reset(div_reset), .div_sync(div_sync), .zero_delay_en(zero_delay_en),
        .int_fb_open(int_fb_open), .external_feedback_input_en(ext_fb_en),
        .auto_switch_en(auto_switch_en), .hitless_en(hitless_en), .out_pd(out_pd),
        .in_pd(in_pd));
    pcra_spi_host pcra_spi_host_i (.mclk(mclk), .three_wire(three_wire), .sclk(sclk),
        .cs_n(cs_n), .sdi(sdi), .sdo(sdo_out), .sdio(sdio));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks=%0d failures=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // page first, then the index: no auto increment to lean on
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] r;
        pcra_spi_host_i.xfer(8'h00, `PCRA_PAGE_SEL_IDX, a[15:8], r);
        pcra_spi_host_i.xfer(8'h00, a[7:0], d, r);
    endtask
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        pcra_spi_host_i.xfer(8'h00, `PCRA_PAGE_SEL_IDX, a[15:8], d);
        pcra_spi_host_i.xfer(8'h80, a[7:0], 8'h00, d);
    endtask
    // bounded wait; controls lag ready by a cycle, so settle two more
    task automatic wait_ready;
        for (int i = 0; i < 300 && device_ready !== 1'b1; i++) @(negedge mclk);
        if (device_ready !== 1'b1) begin
            n_fail++;
            report_and_stop;
        end
        repeat (2) @(negedge mclk);
    endtask
    initial begin
        repeat (2) @(negedge mclk);
        reset = 1'b0;
        @(negedge mclk);
        chk({device_ready, div_reset}, 2'b01);
        wait_ready;
        chk({auto_switch_en, hitless_en, zero_delay_en, out_pd, in_pd}, 17'h18000);
        pcra_spi_host_i.xfer(8'h80, `PCRA_PAGE_SEL_IDX, 8'h00, rd);
        chk(rd, `PCRA_PAGE_RST);
        foreach (ROWS[i]) begin
            wr(ROWS[i][31:16], ROWS[i][15:8]);
            rd_reg(ROWS[i][31:16], rd);
            chk(rd, ROWS[i][7:0]);
            pcra_spi_host_i.xfer(8'h80, `PCRA_PAGE_SEL_IDX, 8'h00, rd);
            chk(rd, ROWS[i][31:24]);
        end
        chk({auto_switch_en, hitless_en, zero_delay_en, int_fb_open, ext_fb_en}, 5'h07);
        chk({out_pd, in_pd}, 14'h2ffa);
        wr(`PCRA_ZDM_ADDR, 8'h00);
        repeat (3) @(negedge mclk);
        chk({auto_switch_en, hitless_en, zero_delay_en, int_fb_open}, 4'hc);
        wr(`PCRA_RESET_CTRL_ADDR, 8'h04);
        chk(n_sync, 1);
        chk({device_ready, in_pd}, 5'h1a);
        // three burns: the third must be refused
        for (int b = 1; b <= 3; b++) begin
            wr(`PCRA_IN_PD_ADDR, 8'(b + 4));
            wr(`PCRA_NVM_CMD_ADDR, `PCRA_NVM_BURN_KEY);
            rd_reg(`PCRA_NVM_CNT_ADDR, rd);
            chk(rd, (b > 2) ? 2 : b);
        end
        rst_pin_n = 1'b0;
        repeat (10) @(negedge mclk);
        chk({device_ready, div_reset}, 2'b01);
        rst_pin_n = 1'b1;
        wait_ready;
        chk({out_pd, in_pd}, 14'h2ff6);
        pcra_spi_host_i.xfer(8'h80, `PCRA_PAGE_SEL_IDX, 8'h00, rd);
        chk(rd, `PCRA_PAGE_RST);
        wr(`PCRA_IN_PD_ADDR, 8'h03);
        wr(`PCRA_RESET_CTRL_ADDR, 8'h02);
        wait_ready;
        chk(in_pd, 4'h6);
        wr(`PCRA_SPI_CFG_ADDR, 8'h08);
        three_wire = 1'b1;
        rd_reg(`PCRA_IN_PD_ADDR, rd);
        chk(rd, 8'h06);
        report_and_stop;
    end
endmodule
